/* File: rtl/audio_switch_panel_controller.sv */
// front-panel controller: routing, step rotation, menus and peer linking
`timescale 1ns/1ps
`default_nettype none
module audio_switch_panel_controller
  import panel_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = panel_pkg::DEBOUNCE_CYC,
  parameter int unsigned HOLD_CYCLES = panel_pkg::MENU_HOLD_CYC,
  parameter int unsigned BLINK_CYCLES = panel_pkg::BLINK_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // front-panel and remote step buttons, high while pressed
  input wire logic [3:0] sel_btn_in,
  input wire logic func_btn_in,
  input wire logic step_btn_in,
  // messages received from linked units
  input wire logic peer_valid_in,
  input wire logic [2:0] peer_kind_in,
  input wire logic [1:0] peer_index_in,
  input wire logic [3:0] peer_addr_in,
  // messages sent to linked units
  output logic msg_valid_out,
  output logic [2:0] msg_kind_out,
  output logic [1:0] msg_index_out,
  output logic [3:0] msg_addr_out,
  // non-volatile storage image
  input wire logic nv_restore_in,
  input wire logic nv_mode_4x1_in,
  input wire logic nv_block_in,
  input wire logic nv_dark_in,
  input wire logic [3:0] nv_addr_in,
  input wire logic [3:0] nv_rot1_in,
  input wire logic [3:0] nv_rot2_in,
  input wire logic [3:0] nv_route1_in,
  input wire logic [2:0] nv_route2_in,
  output logic nv_save_out,
  output logic mode_4x1_out,
  output logic block_out,
  output logic dark_out,
  output logic [3:0] addr_out,
  output logic [3:0] rot1_out,
  output logic [3:0] rot2_out,
  // relay drive and indicators
  output logic [3:0] relay_out1_out,
  output logic [2:0] relay_out2_out,
  output logic [3:0] sel_led_out,
  output logic [1:0] func_led_out,
  output logic [2:0] badge_out,
  output logic step_led_out
);

  localparam int unsigned HW = $clog2(HOLD_CYCLES + 1);
  localparam int unsigned BW = $clog2(BLINK_CYCLES + 1);
  localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES - 1);
  localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // button cleaning

  logic [5:0] raw_btn;
  logic [5:0] lvl;
  logic [5:0] rise;
  logic [5:0] fall;
  assign raw_btn = {step_btn_in, func_btn_in, sel_btn_in};

  // bits 3:0 selectors, 4 function, 5 step
  generate
    for (genvar b = 0; b < 6; b++)
    begin : g_btn
      button_debounce #(
        .STABLE_CYC(DEBOUNCE_CYCLES)
      ) u_deb (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .raw_in(raw_btn[b]),
        .level_out(lvl[b]),
        .rise_out(rise[b]),
        .fall_out(fall[b])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // event merge: one local edge or one peer message per cycle

  ui_state_e state_q;
  logic mode4_q, block_q, dark_q, show2_q;
  logic [3:0] addr_q, rot1_q, rot2_q, route1_q;
  logic [2:0] route2_q;
  logic p_mode4_q, p_block_q, p_dark_q, exit_arm_q;
  logic [3:0] rm_pend_q;
  logic [5:0] peer_held_q;
  logic ev_valid, ev_local;
  logic [2:0] ev_kind;
  logic [1:0] ev_idx;
  logic peer_ok;

  // own address or broadcast only
  assign peer_ok = peer_valid_in && (peer_addr_in == addr_q ||
                   peer_addr_in == BROADCAST_ADDR);

  // lowest local edge wins; a coinciding peer message is dropped
  always_comb
  begin
    ev_valid = 1'b0;
    ev_local = 1'b0;
    ev_kind = MSG_SEL_PRESS;
    ev_idx = 2'd0;
    for (int b = 5; b >= 0; b--)
      if (rise[b] || fall[b])
      begin
        ev_valid = 1'b1;
        ev_local = 1'b1;
        ev_idx = (b < 4) ? 2'(b) : 2'd0;
        if (b == 4)
          ev_kind = rise[b] ? MSG_FUNC_PRESS : MSG_FUNC_RELEASE;
        else if (b == 5)
          ev_kind = rise[b] ? MSG_STEP_PRESS : MSG_STEP_RELEASE;
        else
          ev_kind = rise[b] ? MSG_SEL_PRESS : MSG_SEL_RELEASE;
      end
    if (!ev_valid && peer_ok)
    begin
      ev_valid = 1'b1;
      ev_kind = peer_kind_in;
      ev_idx = peer_index_in;
    end
  end

  // held state of buttons as pressed on linked units
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
      peer_held_q <= '0;
    else if (ev_valid && !ev_local)
      case (ev_kind)
        MSG_SEL_PRESS: peer_held_q[ev_idx] <= 1'b1;
        MSG_SEL_RELEASE: peer_held_q[ev_idx] <= 1'b0;
        MSG_FUNC_PRESS: peer_held_q[4] <= 1'b1;
        MSG_FUNC_RELEASE: peer_held_q[4] <= 1'b0;
        MSG_STEP_PRESS: peer_held_q[5] <= 1'b1;
        MSG_STEP_RELEASE: peer_held_q[5] <= 1'b0;
        default: peer_held_q <= peer_held_q;
      endcase

  logic [5:0] held;
  assign held = lvl | peer_held_q;

  ////////////////////////////////////////////////////////////////////////////
  // outgoing messages

  logic in_menu, send_ok;
  assign in_menu = (state_q == ST_MAIN_MENU) || (state_q == ST_ADDR_MENU);

  // menu address and block presses stay local, all else unless blocked
  always_comb
  begin
    send_ok = ev_valid && ev_local && !block_q;
    if ((ev_kind == MSG_SEL_PRESS || ev_kind == MSG_SEL_RELEASE) &&
        in_menu && (state_q == ST_ADDR_MENU || ev_idx <= 2'd1))
      send_ok = 1'b0;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      msg_valid_out <= 1'b0;
      msg_kind_out <= MSG_SEL_PRESS;
      msg_index_out <= 2'd0;
      msg_addr_out <= BROADCAST_ADDR;
    end
    else
    begin
      msg_valid_out <= send_ok;
      if (send_ok)
      begin
        msg_kind_out <= ev_kind;
        msg_index_out <= ev_idx;
        msg_addr_out <= addr_q;
      end
    end

  ////////////////////////////////////////////////////////////////////////////
  // menu state machine and hold timer

  logic [HW-1:0] hold_q;
  logic hold_done;
  logic [3:0] rot_cur;
  assign hold_done = (state_q == ST_FUNC_HOLD) && held[4] &&
                     (hold_q == HOLD_LAST);
  assign rot_cur = (show2_q && !mode4_q) ? rot2_q : rot1_q;

  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
      hold_q <= '0;
    else if (state_q == ST_FUNC_HOLD && held[4] && !hold_done)
      hold_q <= hold_q + 1'b1;
    else
      hold_q <= '0;

  // menu staging; block, dark and mode changes land only when the menu is left, address and rotation edits at once
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      state_q <= ST_NORMAL;
      exit_arm_q <= 1'b0;
      p_mode4_q <= MODE_4X1_RST;
      p_block_q <= 1'b0;
      p_dark_q <= 1'b0;
      mode4_q <= MODE_4X1_RST;
      block_q <= 1'b0;
      dark_q <= 1'b0;
      addr_q <= ADDR_RST;
      rot1_q <= ROTATION_RST;
      rot2_q <= ROTATION_RST;
      show2_q <= 1'b0;
    end
    else if (nv_restore_in)
    begin
      state_q <= ST_NORMAL;
      mode4_q <= nv_mode_4x1_in;
      block_q <= nv_block_in;
      dark_q <= nv_dark_in;
      addr_q <= (nv_addr_in == 4'h0) ? ADDR_RST : nv_addr_in;
      rot1_q <= nv_rot1_in;
      rot2_q <= nv_rot2_in;
    end
    else
      case (state_q)
        ST_NORMAL:
          if (ev_valid && ev_kind == MSG_FUNC_PRESS)
            state_q <= ST_FUNC_HOLD;
        ST_FUNC_HOLD:
          if (hold_done)
          begin
            state_q <= ST_MAIN_MENU;
            p_mode4_q <= mode4_q;
            p_block_q <= block_q;
            p_dark_q <= dark_q;
          end
          else if (ev_valid && ev_kind == MSG_FUNC_RELEASE)
          begin
            state_q <= ST_NORMAL;
            if (dark_q)
              dark_q <= 1'b0;
            else if (!mode4_q)
              show2_q <= !show2_q;
          end
        ST_MAIN_MENU:
          if (ev_valid && ev_kind == MSG_SEL_PRESS)
            case (ev_idx)
              2'd0:
              begin
                state_q <= ST_ADDR_MENU;
                exit_arm_q <= 1'b0;
              end
              2'd1: p_block_q <= !p_block_q;
              2'd2: p_dark_q <= !p_dark_q;
              default: p_mode4_q <= !p_mode4_q;
            endcase
          else if (ev_valid && ev_kind == MSG_STEP_PRESS)
            state_q <= ST_ROT_MENU;
          else if (ev_valid && ev_kind == MSG_FUNC_RELEASE)
          begin
            state_q <= ST_NORMAL;
            mode4_q <= p_mode4_q;
            block_q <= p_block_q;
            dark_q <= p_dark_q;
            if (p_mode4_q)
              show2_q <= 1'b0;
          end
        ST_ADDR_MENU:
          if (ev_valid && ev_kind == MSG_SEL_PRESS &&
              (addr_q ^ (4'h1 << ev_idx)) != 4'h0)
            addr_q <= addr_q ^ (4'h1 << ev_idx);
          else if (ev_valid && ev_kind == MSG_FUNC_PRESS)
            exit_arm_q <= 1'b1;
          else if (ev_valid && ev_kind == MSG_FUNC_RELEASE && exit_arm_q)
          begin
            state_q <= ST_NORMAL;
            mode4_q <= p_mode4_q;
            block_q <= p_block_q;
            dark_q <= p_dark_q;
            if (p_mode4_q)
              show2_q <= 1'b0;
          end
        ST_ROT_MENU:
          if (ev_valid && ev_kind == MSG_SEL_PRESS)
          begin
            if (show2_q && !mode4_q)
              rot2_q[ev_idx] <= !rot2_q[ev_idx];
            else
              rot1_q[ev_idx] <= !rot1_q[ev_idx];
          end
          else if (ev_valid && ev_kind == MSG_STEP_RELEASE)
          begin
            state_q <= ST_NORMAL;
            mode4_q <= p_mode4_q;
            block_q <= p_block_q;
            dark_q <= p_dark_q;
            if (p_mode4_q)
              show2_q <= 1'b0;
          end
        default: state_q <= ST_NORMAL;
      endcase

  ////////////////////////////////////////////////////////////////////////////
  // routing edits from selectors and step button

  // next rotation member after cur, skipping the fourth input in 3x2
  function automatic logic [1:0] next_input(input logic [3:0] rot,
                                            input logic [1:0] cur,
                                            input logic four);
    logic [1:0] res;
    logic [1:0] c;
    logic found;
    res = cur;
    found = 1'b0;
    for (int k = 1; k <= 4; k++)
    begin
      c = 2'(cur + 2'(k));
      if (!found && rot[c] && (four || c != 2'd3))
      begin
        res = c;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  logic [3:0] cur_route;
  logic [1:0] cur_idx, nxt_idx;
  logic normal_op, sel_ok, others_held;
  assign normal_op = (state_q == ST_NORMAL) || (state_q == ST_FUNC_HOLD);
  assign cur_route = (show2_q && !mode4_q) ? {1'b0, route2_q} : route1_q;
  assign sel_ok = mode4_q || ev_idx != 2'd3;
  assign others_held = |(held[3:0] & ~(4'h1 << ev_idx));
  assign nxt_idx = next_input(rot_cur, cur_idx, mode4_q);

  // lowest active input, or the last slot so stepping starts at the first
  always_comb
  begin
    cur_idx = 2'd3;
    for (int i = 3; i >= 0; i--)
      if (cur_route[i])
        cur_idx = 2'(i);
  end

  logic [3:0] new_route;
  logic route_wr;

  always_comb
  begin
    new_route = cur_route;
    route_wr = 1'b0;
    if (normal_op && ev_valid && ev_kind == MSG_SEL_PRESS && sel_ok)
    begin
      route_wr = 1'b1;
      if (others_held)
        new_route = cur_route | (4'h1 << ev_idx);
      else if (!cur_route[ev_idx])
        new_route = 4'h1 << ev_idx;
    end
    else if (normal_op && ev_valid && ev_kind == MSG_SEL_RELEASE &&
             rm_pend_q[ev_idx])
    begin
      route_wr = 1'b1;
      new_route = cur_route & ~(4'h1 << ev_idx);
    end
    else if (normal_op && ev_valid && ev_kind == MSG_STEP_PRESS &&
             |rot_cur)
    begin
      route_wr = 1'b1;
      new_route = 4'h1 << nxt_idx;
    end
  end

  // removal waits for release and is cancelled by a multi-select press
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
      rm_pend_q <= '0;
    else if (normal_op && ev_valid && ev_kind == MSG_SEL_PRESS)
    begin
      if (others_held)
        rm_pend_q <= '0;
      else
        rm_pend_q[ev_idx] <= cur_route[ev_idx];
    end
    else if (ev_valid && ev_kind == MSG_SEL_RELEASE)
      rm_pend_q[ev_idx] <= 1'b0;

  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      route1_q <= ROUTE1_RST;
      route2_q <= ROUTE2_RST;
    end
    else if (nv_restore_in)
    begin
      route1_q <= nv_route1_in;
      route2_q <= nv_route2_in;
    end
    else if (route_wr)
    begin
      if (show2_q && !mode4_q)
        route2_q <= new_route[2:0];
      else
        route1_q <= new_route;
    end

  // one registered word per update, old and new never both linger
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      relay_out1_out <= '0;
      relay_out2_out <= '0;
    end
    else
    begin
      relay_out1_out <= mode4_q ? route1_q : {1'b0, route1_q[2:0]};
      relay_out2_out <= mode4_q ? 3'h0 : route2_q;
    end

  ////////////////////////////////////////////////////////////////////////////
  // step indicator blinker; a new count restarts it and drops the old

  logic [2:0] blink_left_q;
  logic [BW-1:0] blink_tmr_q;
  logic blink_on_q;

  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      blink_left_q <= '0;
      blink_tmr_q <= '0;
      blink_on_q <= 1'b0;
    end
    else if (normal_op && ev_valid && ev_kind == MSG_STEP_RELEASE)
    begin
      blink_left_q <= 3'(cur_idx) + 3'd1;
      blink_tmr_q <= BLINK_LAST;
      blink_on_q <= 1'b1;
    end
    else if (blink_tmr_q != '0)
      blink_tmr_q <= blink_tmr_q - 1'b1;
    else if (blink_on_q)
    begin
      blink_on_q <= 1'b0;
      blink_left_q <= blink_left_q - 3'd1;
      blink_tmr_q <= BLINK_LAST;
    end
    else if (blink_left_q != 3'd0)
    begin
      blink_on_q <= 1'b1;
      blink_tmr_q <= BLINK_LAST;
    end

  ////////////////////////////////////////////////////////////////////////////
  // indicators and stored image

  logic lights;
  assign lights = !(dark_q && normal_op);

  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      sel_led_out <= '0;
      func_led_out <= FN_OFF;
      badge_out <= BADGE_OFF;
      step_led_out <= 1'b0;
    end
    else
    begin
      step_led_out <= blink_on_q && lights;
      case (state_q)
        ST_MAIN_MENU:
        begin
          sel_led_out <= {p_mode4_q, p_dark_q, p_block_q, 1'b0};
          func_led_out <= FN_OFF;
          badge_out <= BADGE_BRIGHT_WHITE;
        end
        ST_ADDR_MENU:
        begin
          sel_led_out <= addr_q;
          func_led_out <= FN_ORANGE;
          badge_out <= BADGE_GREEN;
        end
        ST_ROT_MENU:
        begin
          sel_led_out <= rot_cur;
          func_led_out <= FN_OFF;
          badge_out <= BADGE_PINK;
        end
        default:
        begin
          sel_led_out <= lights ? cur_route : 4'h0;
          func_led_out <= !lights ? FN_OFF :
                          (show2_q && !mode4_q) ? FN_RED : FN_GREEN;
          badge_out <= !lights ? BADGE_OFF :
                       mode4_q ? BADGE_YELLOW_ORANGE : BADGE_PALE_WHITE;
        end
      endcase
    end

  // save request whenever the stored image moves
  logic [26:0] image_q;
  logic [26:0] image;
  assign image = {mode4_q, block_q, dark_q, addr_q, rot1_q, rot2_q,
                  route1_q, route2_q, 1'b0, 4'h0};

  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      // start equal to the reset image so power-up never saves defaults
      image_q <= {MODE_4X1_RST, 1'b0, 1'b0, ADDR_RST, ROTATION_RST,
                  ROTATION_RST, ROUTE1_RST, ROUTE2_RST, 5'h00};
      nv_save_out <= 1'b0;
    end
    else
    begin
      image_q <= image;
      nv_save_out <= (image != image_q) && !nv_restore_in;
    end

  assign mode_4x1_out = mode4_q;
  assign block_out = block_q;
  assign dark_out = dark_q;
  assign addr_out = addr_q;
  assign rot1_out = rot1_q;
  assign rot2_out = rot2_q;

endmodule
`default_nettype wire

/* File: rtl/button_debounce.sv */
// two-flop synchroniser and stability debouncer for one button
`timescale 1ns/1ps
`default_nettype none
module button_debounce #(
  parameter int unsigned STABLE_CYC = 625000
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // raw and cleaned button
  input wire logic raw_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);

  localparam int unsigned CW = $clog2(STABLE_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(STABLE_CYC - 1);

  logic sync1_q;
  logic sync2_q;
  logic level_q;
  logic [CW-1:0] cnt_q;

  // the first flop feeds only the second
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else
    begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end

  // accept a new level only once it held for the whole window
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      cnt_q <= '0;
      level_q <= 1'b0;
    end
    else if (sync2_q == level_q)
      cnt_q <= '0;
    else if (cnt_q == CNT_LAST)
    begin
      cnt_q <= '0;
      level_q <= sync2_q;
    end
    else
      cnt_q <= cnt_q + 1'b1;

  assign level_out = level_q;
  assign rise_out = (cnt_q == CNT_LAST) && (sync2_q != level_q) && sync2_q;
  assign fall_out = (cnt_q == CNT_LAST) && (sync2_q != level_q) && !sync2_q;

endmodule
`default_nettype wire

/* File: rtl/panel_pkg.sv */
// shared constants and types for the audio switch front-panel controller
package panel_pkg;

  // clock and timing figures
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned DEBOUNCE_MS = 5;
  localparam int unsigned MENU_HOLD_MS = 750;
  localparam int unsigned BLINK_MS = 200;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
  localparam int unsigned MENU_HOLD_CYC = MENU_HOLD_MS * CLK_KHZ;
  localparam int unsigned BLINK_CYC = BLINK_MS * CLK_KHZ;

  // addressing
  localparam logic [3:0] BROADCAST_ADDR = 4'h0;
  localparam logic [3:0] ADDR_RST = 4'h1;

  // reset values of the stored settings
  localparam logic MODE_4X1_RST = 1'b1;
  localparam logic [3:0] ROTATION_RST = 4'hF;
  localparam logic [3:0] ROUTE1_RST = 4'h1;
  localparam logic [2:0] ROUTE2_RST = 3'h0;

  // link message kinds; selector kinds carry a selector index, function and step send index 0
  localparam logic [2:0] MSG_SEL_PRESS = 3'h0;
  localparam logic [2:0] MSG_SEL_RELEASE = 3'h1;
  localparam logic [2:0] MSG_FUNC_PRESS = 3'h2;
  localparam logic [2:0] MSG_FUNC_RELEASE = 3'h3;
  localparam logic [2:0] MSG_STEP_PRESS = 3'h4;
  localparam logic [2:0] MSG_STEP_RELEASE = 3'h5;

  typedef enum logic [2:0] {
    ST_NORMAL = 3'b000,
    ST_FUNC_HOLD = 3'b001,
    ST_MAIN_MENU = 3'b010,
    ST_ADDR_MENU = 3'b011,
    ST_ROT_MENU = 3'b100
  } ui_state_e;

  typedef enum logic [1:0] {
    FN_OFF = 2'b00,
    FN_GREEN = 2'b01,
    FN_RED = 2'b10,
    FN_ORANGE = 2'b11
  } func_color_e;

  typedef enum logic [2:0] {
    BADGE_OFF = 3'b000,
    BADGE_YELLOW_ORANGE = 3'b001,
    BADGE_PALE_WHITE = 3'b010,
    BADGE_BRIGHT_WHITE = 3'b011,
    BADGE_GREEN = 3'b100,
    BADGE_PINK = 3'b101
  } badge_color_e;

endpackage

/* File: testbench/panel_chk.sv */
// port checker for the panel controller
`timescale 1ns/1ps
`default_nettype none
module panel_chk
  import panel_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // watched outputs
  input wire logic mode_4x1_out,
  input wire logic block_out,
  input wire logic dark_out,
  input wire logic msg_valid_out,
  input wire logic [3:0] relay_out1_out,
  input wire logic [2:0] relay_out2_out,
  input wire logic [3:0] sel_led_out,
  input wire logic [1:0] func_led_out,
  input wire logic [2:0] badge_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // the relay word follows the mode one register later
  a_no_d_out1: assert property (
    !$past(mode_4x1_out) |-> !relay_out1_out[3])
    else $error("fourth input on first output");
  a_no_out2_4x1: assert property (
    mode_4x1_out && $past(mode_4x1_out) && $past(mode_4x1_out, 2)
    |-> relay_out2_out == 3'h0) else $error("second output driven");
  a_block_quiet: assert property (
    block_out && $past(block_out) |-> !msg_valid_out)
    else $error("message while blocked");
  a_menu_fn_off: assert property (
    badge_out == BADGE_BRIGHT_WHITE |-> func_led_out == FN_OFF)
    else $error("function light on in menu");
  a_addr_orange: assert property (
    badge_out == BADGE_GREEN |-> func_led_out == FN_ORANGE)
    else $error("address menu colour");
  a_pale_3x2: assert property (
    $stable(mode_4x1_out) && badge_out == BADGE_PALE_WHITE |-> !mode_4x1_out)
    else $error("badge disagrees with mode");
  a_leds_follow: assert property (
    badge_out == BADGE_YELLOW_ORANGE && $past(badge_out) == BADGE_YELLOW_ORANGE
    |-> sel_led_out == relay_out1_out) else $error("lights differ from route");
  a_dark_off: assert property (
    dark_out && badge_out == BADGE_OFF |-> sel_led_out == 4'h0 ##0
    func_led_out == FN_OFF) else $error("light on while dark");
  c_menu: cover property (badge_out == BADGE_BRIGHT_WHITE);
  c_rot: cover property (badge_out == BADGE_PINK);
  c_msg: cover property (msg_valid_out);
endmodule
bind audio_switch_panel_controller panel_chk i_panel_chk (.*);
`default_nettype wire

/* File: testbench/peer_link.sv */
// behavioural linked unit that injects link messages
`timescale 1ns/1ps
`default_nettype none
module peer_link (
  // clock and bench request
  input wire logic clk_in,
  input wire logic send_in,
  input wire logic [2:0] kind_in,
  input wire logic [3:0] addr_in,
  // link towards the controller
  output logic valid_out = 1'h0,
  output logic [2:0] kind_out = 3'h0,
  output logic [1:0] index_out = 2'h0,
  output logic [3:0] addr_out = 4'h0
);
  // idle fields flip every cycle so stale values never look valid
  always @(posedge clk_in)
  begin
    valid_out <= send_in;
    kind_out <= send_in ? kind_in : ~kind_out;
    index_out <= send_in ? 2'h0 : ~index_out;
    addr_out <= send_in ? addr_in : ~addr_out;
  end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench for the panel controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import panel_pkg::*;
  logic clk_in = '0, reset_n_in = '0, func_btn_in = '0, step_btn_in = '0;
  logic nv_restore_in = '0, nv_mode_4x1_in = '0, nv_block_in = '0;
  logic nv_dark_in = '0, send = '0, peer_valid_in, msg_valid_out, nv_save_out;
  logic mode_4x1_out, block_out, dark_out, step_led_out;
  logic [3:0] sel_btn_in = '0, nv_addr_in = '0, nv_rot1_in = '0;
  logic [3:0] nv_rot2_in = '0, nv_route1_in = '0, p_addr = '0, m0;
  logic [2:0] nv_route2_in = '0, p_kind = '0, peer_kind_in, msg_kind_out;
  logic [2:0] relay_out2_out, badge_out;
  logic [1:0] peer_index_in, msg_index_out, func_led_out;
  logic [3:0] peer_addr_in, msg_addr_out, addr_out, rot1_out, rot2_out;
  logic [3:0] relay_out1_out, sel_led_out;
  int n_fail = 0, cmp_count = 0, cyc = 0, blinks = 0, msgs = 0, idx;
  int saves = 0;
  // short counts keep the run brief
  audio_switch_panel_controller #(.DEBOUNCE_CYCLES(4), .HOLD_CYCLES(20),
    .BLINK_CYCLES(3)) i_audio_switch_panel_controller (.*);
  peer_link i_peer_link (.clk_in(clk_in), .send_in(send), .kind_in(p_kind),
    .addr_in(p_addr), .valid_out(peer_valid_in), .kind_out(peer_kind_in),
    .index_out(peer_index_in), .addr_out(peer_addr_in));
  initial forever #4 clk_in = ~clk_in;
  always @(posedge step_led_out) blinks++;
  always @(posedge msg_valid_out) msgs++;
  always @(posedge nv_save_out) saves++;
  // hang guard
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  task end_of_test();
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string s, input logic [3:0] e, input logic [3:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("FAIL %s exp %h got %h", s, e, g);
    end
  endtask
  // {step, func, sel} held long enough to pass the debouncer
  task btn(input logic [5:0] v);
    @(posedge clk_in);
    {step_btn_in, func_btn_in, sel_btn_in} <= v;
    repeat (12) @(posedge clk_in);
  endtask
  task peer(input logic [2:0] kd, input logic [3:0] a);
    @(posedge clk_in);
    send <= 1'h1;
    p_kind <= kd;
    p_addr <= a;
    @(posedge clk_in);
    send <= 1'h0;
    repeat (8) @(posedge clk_in);
  endtask
  // next rotation member after input i among n inputs
  function automatic int nxt(input int i, input logic [3:0] r, input int n);
    for (int j = 1; j <= n; j++)
      if (r[(i + j) % n]) return (i + j) % n;
    return i;
  endfunction
  initial
  begin
    idx = $urandom(32'h0b6a);
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'h1;
    repeat (3) @(posedge clk_in);
    chk("relay1", 4'h1, relay_out1_out);
    chk("badge", 4'h1, {1'h0, badge_out});
    m0 = 4'(msgs);
    btn(6'h02);
    chk("relay1", 4'h2, relay_out1_out);
    chk("mkind", {1'h0, MSG_SEL_PRESS}, {1'h0, msg_kind_out});
    chk("midx", 4'h1, {2'h0, msg_index_out});
    chk("maddr", ADDR_RST, msg_addr_out);
    chk("saves", 4'h1, 4'(saves));
    btn(6'h06);
    btn(6'h04);
    btn(6'h00);
    chk("relay1", 4'h6, relay_out1_out);
    chk("msgs", 4'h4, 4'(msgs) - m0);
    btn(6'h04);
    btn(6'h00);
    chk("relay1", 4'h2, relay_out1_out);
    btn(6'h10);
    repeat (30) @(posedge clk_in);
    chk("badge", 4'h3, {1'h0, badge_out});
    btn(6'h30);
    chk("badge", 4'h5, {1'h0, badge_out});
    btn(6'h20);
    btn(6'h22);
    btn(6'h20);
    btn(6'h00);
    chk("rot1", 4'hD, rot1_out);
    idx = 1;
    repeat (3 + $urandom % 4)
    begin
      btn(6'h20);
      idx = nxt(idx, 4'hD, 4);
      chk("relay1", 4'h1 << idx, relay_out1_out);
      blinks = 0;
      btn(6'h00);
      repeat (40) @(posedge clk_in);
      chk("blinks", 4'(idx + 1), 4'(blinks));
    end
    btn(6'h10);
    repeat (30) @(posedge clk_in);
    btn(6'h18);
    btn(6'h10);
    btn(6'h00);
    chk("mode", 4'h0, {3'h0, mode_4x1_out});
    chk("badge", 4'h2, {1'h0, badge_out});
    btn(6'h10);
    btn(6'h00);
    chk("fled", 4'h2, {2'h0, func_led_out});
    m0 = relay_out1_out;
    btn(6'h01);
    btn(6'h00);
    btn(6'h08);
    btn(6'h00);
    chk("relay2", 4'h1, {1'h0, relay_out2_out});
    chk("relay1", m0, relay_out1_out);
    btn(6'h10);
    repeat (30) @(posedge clk_in);
    btn(6'h11);
    chk("badge", 4'h4, {1'h0, badge_out});
    chk("fled", 4'h3, {2'h0, func_led_out});
    btn(6'h10);
    btn(6'h00);
    m0 = 4'(msgs);
    btn(6'h02);
    btn(6'h00);
    chk("msgs", m0, 4'(msgs));
    chk("addr", ADDR_RST ^ 4'h2, addr_out);
    btn(6'h10);
    btn(6'h00);
    chk("badge", 4'h2, {1'h0, badge_out});
    peer(3'h4, 4'h5);
    chk("relay2", 4'h1, {1'h0, relay_out2_out});
    peer(3'h4, 4'h0);
    peer(3'h5, 4'h0);
    chk("relay2", 4'h2, {1'h0, relay_out2_out});
    @(posedge clk_in);
    nv_mode_4x1_in <= 1'($urandom);
    nv_addr_in <= 4'($urandom) | 4'h1;
    nv_rot1_in <= 4'($urandom);
    nv_rot2_in <= 4'($urandom);
    nv_route1_in <= 4'($urandom) & 4'h7;
    nv_route2_in <= 3'($urandom);
    {nv_block_in, nv_dark_in, nv_restore_in} <= 3'h7;
    @(posedge clk_in);
    nv_restore_in <= 1'h0;
    repeat (4) @(posedge clk_in);
    chk("addr", nv_addr_in, addr_out);
    chk("rot1", nv_rot1_in, rot1_out);
    chk("rot2", nv_rot2_in, rot2_out);
    chk("block", 4'h1, {3'h0, block_out});
    chk("mode", {3'h0, nv_mode_4x1_in}, {3'h0, mode_4x1_out});
    m0 = 4'(msgs);
    btn(6'h04);
    btn(6'h00);
    chk("msgs", m0, 4'(msgs));
    chk("sled", 4'h0, sel_led_out);
    btn(6'h10);
    btn(6'h00);
    chk("dark", 4'h0, {3'h0, dark_out});
    end_of_test();
  end
endmodule
`default_nettype wire
